/* bench/ssfo_host_model.sv */
// Host controller model that captures the feedback output like a timer input.
`default_nettype none
module ssfo_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic feedback_output,
  output int high_cnt,
  output int period_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int run_hi; // High cycles seen since the last rising edge.
  int run_all; // All cycles since the last rising edge.
  logic prev_lvl; // Output level seen at the previous edge.
  // Record high time and period at each rising edge, as a capture timer does.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_hi <= 0;
      run_all <= 0;
      prev_lvl <= 1'b0;
      high_cnt <= 0;
      period_cnt <= 0;
    end else begin
      prev_lvl <= feedback_output;
      if (feedback_output && !prev_lvl) begin
        high_cnt <= run_hi;
        period_cnt <= run_all;
        run_hi <= 1;
        run_all <= 1;
      end else begin
        run_hi <= run_hi + (feedback_output ? 1 : 0);
        run_all <= run_all + 1;
      end
    end
  end
endmodule // ssfo_host_model
`default_nettype wire

/* bench/ssfo_status_feedback_test.sv */
// Self-checking testbench of the status feedback output block.
`default_nettype none
module ssfo_status_feedback_test
  import ssfo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLOW = 200; // Shortened slow PWM period in cycles.
  localparam int FAST = 40; // Shortened fast PWM period in cycles.
  localparam int MSC = 20; // Shortened millisecond in cycles.
  localparam int SETTLE_CYC = 2 * MSC; // Settle time of two milliseconds in cycles.
  logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, feedback_output, motion_cmd = 1'b0, new_cmd = 1'b0;
  logic motor_enable = 1'b0, motor_shutdown = 1'b0, vel_cmd_changing = 1'b0;
  logic torque_achieved = 1'b0, bus_v_low = 1'b0, speed_limited = 1'b0;
  logic [1:0] op_mode = 2'h0;
  logic signed [23:0] target_pos = 24'h0, actual_pos = 24'h0;
  logic signed [15:0] target_vel = 16'h0, actual_vel = 16'h0, shaft_torque = 16'h0;
  int high_cnt, period_cnt, n_fail = 0, comparisons = 0, n;
  logic [31:0] q;
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  ssfo_status_feedback #(.PWM_SLOW_CYC(SLOW), .PWM_FAST_CYC(FAST), .MS_CYC(MSC))
    u_ssfo_status_feedback (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .motor_enable(motor_enable),
    .motor_shutdown(motor_shutdown), .op_mode(op_mode), .motion_cmd(motion_cmd),
    .new_cmd(new_cmd), .target_pos(target_pos), .actual_pos(actual_pos),
    .target_vel(target_vel), .actual_vel(actual_vel), .vel_cmd_changing(vel_cmd_changing),
    .shaft_torque(shaft_torque), .torque_achieved(torque_achieved), .bus_v_low(bus_v_low),
    .speed_limited(speed_limited), .feedback_output(feedback_output));
  ssfo_host_model u_ssfo_host_model (.clk(clk), .sys_rst(sys_rst),
    .feedback_output(feedback_output), .high_cnt(high_cnt), .period_cnt(period_cnt));
  // Print the counts and the verdict, then end the run.
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Compare one value against its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // Let c clock edges pass.
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  // One Avalon transfer; the request holds until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      summarize();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  // Select the output mode and the PWM rate.
  task automatic set_mode(input logic [3:0] m, input logic fast);
    bus(1'b1, OFS_CTRL, {23'h0, fast, 4'h0, m});
  endtask
  // Compare the output level after a short settling delay.
  task automatic lvl(input logic v, input string what);
    cyc(3);
    chk({31'h0, feedback_output}, {31'h0, v}, what);
  endtask
  // Bounded wait for an output level; n returns the cycles taken.
  task automatic wait_lvl(input logic v);
    n = 0;
    while (feedback_output !== v && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, feedback_output}, {31'h0, v}, "wait for level");
  endtask
  // Reset values, an unmapped read and a settle-time write.
  task automatic t_regs();
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(q, {28'h0, MODE_RST}, "ctrl reset");
    bus(1'b0, OFS_POS_WIN, 32'h0);
    chk(q, {8'h0, POS_WIN_RST}, "window reset");
    bus(1'b0, OFS_VEL_PCT, 32'h0);
    chk(q, {25'h0, VEL_PCT_RST}, "percent reset");
    bus(1'b0, OFS_SETTLE, 32'h0);
    chk(q, {16'h0, SETTLE_RST}, "settle reset");
    avs_byteenable <= 4'h2;
    bus(1'b1, OFS_CTRL, {23'h0, 1'b1, 4'h0, 4'(M_SET_VEL)});
    avs_byteenable <= 4'hF;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(q, {23'h0, 1'b1, 8'h00}, "byte lane write");
    bus(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0, "unmapped read");
    bus(1'b1, OFS_SETTLE, 32'h00000002);
    bus(1'b0, OFS_SETTLE, 32'h0);
    chk(q, 32'h00000002, "settle write");
  endtask
  // Servo on follows enable and shutdown.
  task automatic t_servo();
    motor_enable <= 1'b1;
    lvl(1'b1, "servo on");
    motor_shutdown <= 1'b1;
    lvl(1'b0, "servo shutdown");
    motor_shutdown <= 1'b0;
  endtask
  // Settled and latched position modes at the window edge.
  task automatic t_pos();
    set_mode(M_SET_POS, 1'b0);
    target_pos <= 24'sd1000;
    actual_pos <= 24'sd1016;
    motion_cmd <= 1'b1;
    lvl(1'b0, "moving");
    motion_cmd <= 1'b0;
    wait_lvl(1'b1);
    chk(32'(n >= SETTLE_CYC), 32'h1, "settle time");
    actual_pos <= 24'sd1017;
    lvl(1'b0, "left window");
    actual_pos <= 24'sd1000;
    wait_lvl(1'b1);
    chk(32'(n >= SETTLE_CYC), 32'h1, "settle restart");
    motor_enable <= 1'b0;
    lvl(1'b0, "disabled");
    motor_enable <= 1'b1;
    set_mode(M_SET_POS_LAT, 1'b0);
    wait_lvl(1'b1);
    actual_pos <= 24'sd2000;
    lvl(1'b1, "latched hold");
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h0000000D, "status latched");
    new_cmd <= 1'b1;
    @(posedge clk);
    new_cmd <= 1'b0;
    lvl(1'b0, "latch cleared");
  endtask
  // Torque PWM duty and period while motion is commanded.
  task automatic t_pwm(input logic [3:0] m, input logic fast, input int per);
    set_mode(m, fast);
    shaft_torque <= 16'h0000;
    cyc(SLOW + 3 * per);
    chk(32'(period_cnt), 32'(per), "pwm period");
    chk(32'(high_cnt), 32'(per * DUTY_HALF_PCT / PCT_FULL), "zero torque duty");
    shaft_torque <= 16'h8000;
    cyc(3 * per);
    chk(32'(high_cnt), 32'(per * DUTY_HALF_PCT / PCT_FULL - per * DUTY_SPAN_PCT / PCT_FULL),
      "cw peak duty");
  endtask
  // Velocity family, in-range and availability by operating mode.
  task automatic t_vel();
    op_mode <= 2'(OP_VEL);
    target_vel <= 16'sd1000;
    actual_vel <= 16'sd1050;
    set_mode(M_SET_VEL, 1'b0);
    vel_cmd_changing <= 1'b1;
    lvl(1'b0, "ramping");
    vel_cmd_changing <= 1'b0;
    wait_lvl(1'b1);
    chk(32'(n >= SETTLE_CYC), 32'h1, "velocity settle");
    actual_vel <= 16'sd1051;
    lvl(1'b0, "velocity window");
    actual_vel <= 16'sd1000;
    set_mode(M_SET_VEL_LAT, 1'b0);
    wait_lvl(1'b1);
    actual_vel <= 16'sd1200;
    lvl(1'b1, "velocity latch");
    new_cmd <= 1'b1;
    @(posedge clk);
    new_cmd <= 1'b0;
    lvl(1'b0, "velocity latch clear");
    set_mode(M_VEL_RANGE, 1'b0);
    actual_vel <= 16'sd1000;
    lvl(1'b1, "in range");
    actual_vel <= 16'sd1051;
    lvl(1'b0, "out of range");
    vel_cmd_changing <= 1'b1;
    t_pwm(M_SET_VEL_TRQ, 1'b1, FAST);
    t_pwm(M_SET_VEL_LAT_TRQ, 1'b0, SLOW);
    vel_cmd_changing <= 1'b0;
    actual_vel <= 16'sd1000;
    op_mode <= 2'(OP_POS);
    set_mode(M_SET_VEL, 1'b0);
    cyc(2 * SETTLE_CYC);
    lvl(1'b0, "velocity mode unavailable");
  endtask
  // Settled torque mode and its drop-out causes.
  task automatic t_trq();
    op_mode <= 2'(OP_TRQ);
    set_mode(M_SET_TRQ, 1'b0);
    torque_achieved <= 1'b1;
    lvl(1'b1, "torque produced");
    torque_achieved <= 1'b0;
    lvl(1'b0, "torque not produced");
    torque_achieved <= 1'b1;
    bus_v_low <= 1'b1;
    lvl(1'b0, "bus voltage low");
    bus_v_low <= 1'b0;
    speed_limited <= 1'b1;
    lvl(1'b0, "speed limited");
    speed_limited <= 1'b0;
    op_mode <= 2'(OP_VEL);
    lvl(1'b0, "torque mode unavailable");
  endtask
  // Main sequence after ten reset cycles.
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_servo();
    t_pos();
    actual_pos <= 24'sd1000;
    motion_cmd <= 1'b1;
    t_pwm(M_SET_POS_TRQ, 1'b1, FAST);
    t_pwm(M_SET_POS_LAT_TRQ, 1'b0, SLOW);
    motion_cmd <= 1'b0;
    cyc(SETTLE_CYC + 5);
    actual_pos <= 24'sd2000;
    lvl(1'b1, "torque latch hold");
    t_vel();
    t_trq();
    summarize();
  end
  // Cut a hung run short.
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule // ssfo_status_feedback_test
`default_nettype wire

/* logic/ssfo_pkg.sv */
// Constants, register map and mode encodings of the servo status feedback output.
`default_nettype none
package ssfo_pkg;
  // Clock rate and the time units that the counters are derived from.
  localparam int CLK_HZ = 10_000_000;
  localparam int PWM_SLOW_HZ = 45;
  localparam int PWM_FAST_HZ = 482;
  localparam int MS_PER_S = 1000;
  // Width of the PWM period counter, wide enough for the slow period.
  localparam int CNT_W = 18;
  // Duty figures in percent of the period.
  localparam int DUTY_HALF_PCT = 50;
  localparam int DUTY_SPAN_PCT = 45;
  localparam int PCT_FULL = 100;
  // Torque input is signed with full peak torque at plus or minus two to the fifteenth.
  localparam int TRQ_SHIFT = 15;
  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_POS_WIN = 8'h04;
  localparam logic [7:0] OFS_VEL_PCT = 8'h08;
  localparam logic [7:0] OFS_SETTLE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Field positions inside the control register.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FAST_BIT = 8;
  // Values after reset.
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic FAST_RST = 1'b0;
  localparam logic [23:0] POS_WIN_RST = 24'h000010;
  localparam logic [6:0] VEL_PCT_RST = 7'h05;
  localparam logic [15:0] SETTLE_RST = 16'h000A;
  // Output mode selection held in the control register.
  typedef enum logic [3:0] {
    M_SERVO_ON, M_SET_POS, M_SET_POS_LAT, M_SET_POS_TRQ, M_SET_POS_LAT_TRQ,
    M_SET_VEL, M_SET_VEL_LAT, M_SET_VEL_TRQ, M_SET_VEL_LAT_TRQ,
    M_VEL_RANGE, M_SET_TRQ
  } ssfo_mode_e;
  // Operating mode of the motor as reported by the motion logic.
  typedef enum logic [1:0] {OP_POS, OP_VEL, OP_TRQ} ssfo_op_e;
endpackage
`default_nettype wire

/* logic/ssfo_status_feedback.sv */
// Status feedback output generator with its Avalon-MM register slave.
`default_nettype none
module ssfo_status_feedback
  import ssfo_pkg::*;
#(
  parameter int PWM_SLOW_CYC = CLK_HZ / PWM_SLOW_HZ,
  parameter int PWM_FAST_CYC = CLK_HZ / PWM_FAST_HZ,
  parameter int MS_CYC = CLK_HZ / MS_PER_S
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic motor_enable,
  input wire logic motor_shutdown,
  input wire logic [1:0] op_mode,
  input wire logic motion_cmd,
  input wire logic new_cmd,
  input wire logic signed [23:0] target_pos,
  input wire logic signed [23:0] actual_pos,
  input wire logic signed [15:0] target_vel,
  input wire logic signed [15:0] actual_vel,
  input wire logic vel_cmd_changing,
  input wire logic signed [15:0] shaft_torque,
  input wire logic torque_achieved,
  input wire logic bus_v_low,
  input wire logic speed_limited,
  output logic feedback_output
);

  // Half period and duty span for each PWM frequency.
  localparam logic [CNT_W-1:0] SLOW_PER = CNT_W'(PWM_SLOW_CYC);
  localparam logic [CNT_W-1:0] FAST_PER = CNT_W'(PWM_FAST_CYC);
  localparam logic [CNT_W-1:0] SLOW_HALF = CNT_W'(PWM_SLOW_CYC * DUTY_HALF_PCT / PCT_FULL);
  localparam logic [CNT_W-1:0] FAST_HALF = CNT_W'(PWM_FAST_CYC * DUTY_HALF_PCT / PCT_FULL);
  localparam logic [CNT_W-1:0] SLOW_SPAN = CNT_W'(PWM_SLOW_CYC * DUTY_SPAN_PCT / PCT_FULL);
  localparam logic [CNT_W-1:0] FAST_SPAN = CNT_W'(PWM_FAST_CYC * DUTY_SPAN_PCT / PCT_FULL);
  localparam logic [15:0] MS_LAST = 16'(MS_CYC - 1);

  logic [3:0] mode_code_reg; // Selected output mode code.
  logic fast_reg; // High selects the fast PWM frequency.
  logic [23:0] pos_win_reg; // Position window in counts.
  logic [6:0] vel_pct_reg; // Velocity window in percent.
  logic [15:0] settle_reg; // Settle time in milliseconds.
  logic wait_reg; // Drives waitrequest.
  logic [31:0] rdata_reg; // Drives readdata.
  logic [31:0] wmask; // Byte enables spread to bits.
  logic [31:0] rd_next; // Read multiplexer.
  logic bus_req; // A read or write is pending.
  logic bus_wr; // A write takes effect this edge.
  ssfo_mode_e mode; // Typed view of the mode code.

  assign mode = ssfo_mode_e'(mode_code_reg);
  assign bus_req = avs_read | avs_write;
  assign bus_wr = avs_write & ~wait_reg;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Waitrequest is high at rest and drops for one cycle after a request is seen.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
    end
  end

  // Configuration writes; byte lanes outside a narrow register are ignored.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_code_reg <= MODE_RST;
      fast_reg <= FAST_RST;
      pos_win_reg <= POS_WIN_RST;
      vel_pct_reg <= VEL_PCT_RST;
      settle_reg <= SETTLE_RST;
    end else if (bus_wr) begin
      unique case (avs_address)
        OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            mode_code_reg <= avs_writedata[CTRL_MODE_LSB +: 4];
          end
          if (avs_byteenable[1]) begin
            fast_reg <= avs_writedata[CTRL_FAST_BIT];
          end
        end
        OFS_POS_WIN: begin
          pos_win_reg <= (pos_win_reg & ~wmask[23:0]) | (avs_writedata[23:0] & wmask[23:0]);
        end
        OFS_VEL_PCT: begin
          vel_pct_reg <= (vel_pct_reg & ~wmask[6:0]) | (avs_writedata[6:0] & wmask[6:0]);
        end
        OFS_SETTLE: begin
          settle_reg <= (settle_reg & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
        end
        default: begin
          // Status and unmapped offsets ignore writes.
        end
      endcase
    end
  end

  // Settling and output state, declared here for the status read.
  logic settled; // Target settled for the settle time.
  logic latch_reg; // Latched variants hold the output.
  logic mode_legal; // Mode allowed in the present operation.

  // Read data is chosen at the edge that lowers waitrequest.
  always_comb begin
    unique case (avs_address)
      OFS_CTRL: rd_next = {23'h000000, fast_reg, 4'h0, mode_code_reg};
      OFS_POS_WIN: rd_next = {8'h00, pos_win_reg};
      OFS_VEL_PCT: rd_next = {25'h0000000, vel_pct_reg};
      OFS_SETTLE: rd_next = {16'h0000, settle_reg};
      OFS_STATUS: rd_next = {28'h0000000, mode_legal, latch_reg, settled, feedback_output};
      default: rd_next = 32'h00000000;
    endcase
  end

  // Capture read data so it stands while waitrequest is low.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= 32'h00000000;
    end else if (bus_req & wait_reg) begin
      rdata_reg <= rd_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

  // Window comparisons for position counts and velocity percent.
  logic signed [24:0] pos_diff; // Position error.
  logic [24:0] pos_abs; // Magnitude of position error.
  logic signed [16:0] vel_diff; // Velocity error.
  logic [16:0] vel_abs; // Magnitude of velocity error.
  logic [16:0] tgt_abs; // Magnitude of target velocity.
  logic pos_in_win; // Position within plus or minus counts.
  logic vel_in_win; // Velocity within plus or minus percent.
  logic base_ok; // Enabled and not shut down.
  logic is_vel; // Selected mode belongs to the velocity family.

  assign pos_diff = 25'(actual_pos) - 25'(target_pos);
  assign pos_abs = pos_diff[24] ? 25'(-pos_diff) : 25'(pos_diff);
  assign pos_in_win = pos_abs <= {1'b0, pos_win_reg};
  assign vel_diff = 17'(actual_vel) - 17'(target_vel);
  assign vel_abs = vel_diff[16] ? 17'(-vel_diff) : 17'(vel_diff);
  assign tgt_abs = target_vel[15] ? 17'(-17'(target_vel)) : 17'(target_vel);
  assign vel_in_win = (24'(vel_abs) * 24'(PCT_FULL)) <= (24'(vel_pct_reg) * 24'(tgt_abs));
  assign base_ok = motor_enable & ~motor_shutdown;
  assign is_vel = mode inside {M_SET_VEL, M_SET_VEL_LAT, M_SET_VEL_TRQ, M_SET_VEL_LAT_TRQ};

  // Restart conditions for the settle timer.
  logic signed [23:0] pos_tgt_prev; // Target position one cycle ago.
  logic signed [15:0] vel_tgt_prev; // Target velocity one cycle ago.
  logic in_win; // Window of the selected family.
  logic moving; // Motion or velocity ramp commanded.
  logic restart; // Settle timer starts over.
  logic [15:0] ms_div_reg; // Cycles within the current millisecond.
  logic [15:0] settle_cnt_reg; // Whole milliseconds spent settled.

  assign in_win = is_vel ? vel_in_win : pos_in_win;
  assign moving = is_vel ? vel_cmd_changing : motion_cmd;
  assign restart = ~in_win | moving | ~base_ok | (target_pos != pos_tgt_prev)
                 | (target_vel != vel_tgt_prev);
  assign settled = ~restart & (settle_cnt_reg >= settle_reg);

  // Remember the targets to see when they change.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pos_tgt_prev <= 24'sh000000;
      vel_tgt_prev <= 16'sh0000;
    end else begin
      pos_tgt_prev <= target_pos;
      vel_tgt_prev <= target_vel;
    end
  end

  // The millisecond divider restarts with the timer, so a settle time is never short.
  always_ff @(posedge clk) begin
    if (sys_rst || restart) begin
      ms_div_reg <= 16'h0000;
      settle_cnt_reg <= 16'h0000;
    end else if (ms_div_reg == MS_LAST) begin
      ms_div_reg <= 16'h0000;
      if (settle_cnt_reg != 16'hFFFF) begin
        settle_cnt_reg <= settle_cnt_reg + 16'h0001;
      end
    end else begin
      ms_div_reg <= ms_div_reg + 16'h0001;
    end
  end

  // Quiet cycles since the last restart, counted apart from the timer so its check is independent.
  logic [31:0] quiet_cnt_reg; // Saturating count of cycles with no restart.
  always_ff @(posedge clk) begin
    if (sys_rst || restart) begin
      quiet_cnt_reg <= 32'h00000000;
    end else if (quiet_cnt_reg != 32'hFFFFFFFF) begin
      quiet_cnt_reg <= quiet_cnt_reg + 32'h00000001;
    end
  end

  // Latch for the latched variants; cleared by disable, shutdown or a new command.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_reg <= 1'b0;
    end else if (~base_ok | new_cmd | ~(mode inside {M_SET_POS_LAT, M_SET_POS_LAT_TRQ,
                 M_SET_VEL_LAT, M_SET_VEL_LAT_TRQ})) begin
      latch_reg <= 1'b0;
    end else if (settled) begin
      latch_reg <= 1'b1;
    end
  end

  // PWM period counter; period and duty are loaded only at the wrap.
  logic [CNT_W-1:0] pwm_cnt_reg; // Position in the period.
  logic [CNT_W-1:0] period_reg; // Period in force.
  logic [CNT_W-1:0] duty_reg; // High time in force.
  logic [CNT_W-1:0] half_sel; // Half period of the selected rate.
  logic [CNT_W-1:0] span_sel; // 45 percent span of the selected rate.
  logic signed [15:0] trq_c; // Torque clamped to symmetric range.
  logic signed [39:0] trq_prod; // Span scaled by torque.
  logic [CNT_W-1:0] duty_next; // Duty for the next period.
  logic pwm_wrap; // Last cycle of the period.
  logic pwm_level; // PWM waveform level.

  assign half_sel = fast_reg ? FAST_HALF : SLOW_HALF;
  assign span_sel = fast_reg ? FAST_SPAN : SLOW_SPAN;
  assign trq_c = (shaft_torque == 16'sh8000) ? 16'sh8001 : shaft_torque;
  assign trq_prod = $signed({22'h000000, span_sel}) * 40'(trq_c);
  // Negative torque is clockwise and shortens the pulse toward 5 percent.
  assign duty_next = half_sel + CNT_W'(trq_prod >>> TRQ_SHIFT);
  assign pwm_wrap = pwm_cnt_reg >= period_reg - CNT_W'(1);
  assign pwm_level = pwm_cnt_reg < duty_reg;

  // Free-running period counter, so a fresh motion can start part way through a pulse.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwm_cnt_reg <= '0;
      period_reg <= SLOW_PER;
      duty_reg <= SLOW_HALF;
    end else if (pwm_wrap) begin
      pwm_cnt_reg <= '0;
      period_reg <= fast_reg ? FAST_PER : SLOW_PER;
      duty_reg <= duty_next;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + CNT_W'(1);
    end
  end

  // Mode availability against the operating mode.
  always_comb begin
    unique case (mode)
      M_SERVO_ON: mode_legal = 1'b1;
      M_SET_POS, M_SET_POS_LAT, M_SET_POS_TRQ, M_SET_POS_LAT_TRQ: begin
        mode_legal = op_mode == OP_POS;
      end
      M_SET_VEL, M_SET_VEL_LAT, M_SET_VEL_TRQ, M_SET_VEL_LAT_TRQ, M_VEL_RANGE: begin
        mode_legal = op_mode == OP_VEL;
      end
      M_SET_TRQ: mode_legal = op_mode == OP_TRQ;
      default: mode_legal = 1'b0;
    endcase
  end

  // Level that the selected mode asks for, before the enable gate.
  logic mode_level; // Per-mode output level.
  always_comb begin
    unique case (mode)
      M_SERVO_ON: mode_level = 1'b1;
      M_SET_POS: mode_level = settled;
      M_SET_VEL: mode_level = settled;
      M_SET_POS_LAT, M_SET_VEL_LAT: mode_level = settled | latch_reg;
      M_SET_POS_TRQ: mode_level = motion_cmd ? pwm_level : settled;
      M_SET_VEL_TRQ: mode_level = vel_cmd_changing ? pwm_level : settled;
      M_SET_POS_LAT_TRQ: begin
        mode_level = latch_reg | (motion_cmd ? pwm_level : settled);
      end
      M_SET_VEL_LAT_TRQ: begin
        mode_level = latch_reg | (vel_cmd_changing ? pwm_level : settled);
      end
      M_VEL_RANGE: mode_level = vel_in_win;
      M_SET_TRQ: begin
        mode_level = torque_achieved & ~bus_v_low & ~speed_limited;
      end
      default: mode_level = 1'b0;
    endcase
  end

  // Registered output, forced off when disabled, shut down or mode unavailable.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      feedback_output <= 1'b0;
    end else begin
      feedback_output <= base_ok & mode_legal & mode_level;
    end
  end

  a_gate_enable: assert property (@(posedge clk) disable iff (sys_rst)
    !base_ok |=> !feedback_output) else $error("output high while disabled");
  a_servo_on: assert property (@(posedge clk) disable iff (sys_rst)
    (mode == M_SERVO_ON) && base_ok |=> feedback_output) else $error("servo on low");
  a_range_drop: assert property (@(posedge clk) disable iff (sys_rst)
    (mode == M_SET_POS) && (!pos_in_win || motion_cmd) |=> !feedback_output)
    else $error("position output high out of window");
  a_latch_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (mode == M_SET_POS_LAT) && latch_reg && base_ok && !new_cmd && (op_mode == OP_POS)
    |=> feedback_output) else $error("latched output dropped");
  a_settle_time: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(settled) && (settle_reg == 16'h0002) |-> !$past(restart, 2) && !$past(restart))
    else $error("settled too early");
  a_restart_clr: assert property (@(posedge clk) disable iff (sys_rst)
    restart |=> (settle_cnt_reg == 16'h0000) && (ms_div_reg == 16'h0000))
    else $error("settle timer not restarted");
  a_pwm_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    !pwm_wrap |=> $stable(duty_reg) && $stable(period_reg)) else $error("duty changed mid period");
  a_zero_trq: assert property (@(posedge clk) disable iff (sys_rst)
    pwm_wrap && (shaft_torque == 16'sh0000) |=> duty_reg == $past(half_sel))
    else $error("zero torque duty");
  a_pwm_motion: assert property (@(posedge clk) disable iff (sys_rst)
    (mode == M_SET_POS_TRQ) && base_ok && mode_legal && motion_cmd |=> feedback_output ==
    $past(pwm_level)) else $error("no torque pwm in motion");
  a_vel_opmode: assert property (@(posedge clk) disable iff (sys_rst)
    is_vel && (op_mode != OP_VEL) |=> !feedback_output) else $error("velocity mode outside op");
  a_trq_limit: assert property (@(posedge clk) disable iff (sys_rst)
    (mode == M_SET_TRQ) && (bus_v_low || speed_limited || op_mode != OP_TRQ) |=> !feedback_output)
    else $error("torque output high while limited");
  a_wait_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest answer wrong");
  a_settle_count: assert property (@(posedge clk) disable iff (sys_rst)
    settled |-> quiet_cnt_reg >= 32'(settle_reg) * 32'(MS_CYC))
    else $error("settle time cut short");
  a_latch_clear: assert property (@(posedge clk) disable iff (sys_rst)
    new_cmd |=> !latch_reg) else $error("latch kept after new command");
  a_vel_drop: assert property (@(posedge clk) disable iff (sys_rst)
    (mode == M_SET_VEL) && (vel_cmd_changing || !vel_in_win) |=> !feedback_output)
    else $error("velocity output high while ramping");
  a_range_level: assert property (@(posedge clk) disable iff (sys_rst)
    (mode == M_VEL_RANGE) && base_ok && (op_mode == OP_VEL)
    |=> feedback_output == $past(vel_in_win)) else $error("in range output wrong");
  a_trq_level: assert property (@(posedge clk) disable iff (sys_rst)
    (mode == M_SET_TRQ) && base_ok && (op_mode == OP_TRQ) && torque_achieved && !bus_v_low
    && !speed_limited |=> feedback_output) else $error("torque output low while produced");

endmodule // ssfo_status_feedback
`default_nettype wire
